// ===== rtl/upt_tx_ctrl.sv
// What this block does
// - With one-way mode off, behave exactly as the plain sublayers.
// - One-way enable is a boolean management input, bit 0.5 equivalent.
// - Fast mode, one-way off: link not OK forces idle at once.
// - Fast mode, one-way on: link status ignored, data still sent.
// - Fault generator passes code bits if signal on or one-way set, but sends the idle code instead while idle is forced.
// - Signal off, one-way off: repeat far-end fault cycles, dropped mid-cycle when either turns on.
// - Gigabit one-way: transmit select held at DATA, no negotiation.
// - Otherwise negotiation starts initially and on CONFIGURATION.
// - Ordered sets supplied to code-group process every tick.
// - Idle sets on IDLE select and between packets.
// - Enable rise under DATA: start set, then data until enable falls.
// - After enable falls, end-of-packet sets are sent.
// - Error at fall: extend sets while error high, two ticks late.
// - Extend error code during extension gives error-propagation sets.
// - Both low: no extend set, idle resumes right after the end-of-packet sets.
// - Error while enabled gives error set, except during start set.
`timescale 1ns/100ps
module upt_tx_ctrl (
  input wire logic clk,
  input wire logic rst,
  input wire logic oneWayTxEnable,
  input wire upt_pkg::upt_xmit_e anXmit,
  input wire logic gtxClkPin,
  input wire logic txEnPin,
  input wire logic txErPin,
  input wire logic [7:0] txdPin,
  input wire logic linkOkPin,
  input wire logic signalDetectPin,
  input wire logic [4:0] fxCodeIn,
  output upt_pkg::upt_os_e osKind,
  output logic [7:0] osData,
  output logic osStrobe,
  output upt_pkg::upt_xmit_e xmitEff,
  output logic anStart,
  output logic fxForceIdle,
  output logic [4:0] fxCodeOut,
  output logic fefActive
);
  import upt_pkg::*;

  // ****************************************************************
  // Input synchronisers
  // ****************************************************************
  logic gtxClkS;
  logic txEnS;
  logic txErS;
  logic [7:0] txdS;
  logic linkOkS;
  logic signalDetS;

  upt_sync2 #(.W(12)) uSyncGmii (
    .clk(clk),
    .rst(rst),
    .d({gtxClkPin, txEnPin, txErPin, txdPin, linkOkPin}),
    .q({gtxClkS, txEnS, txErS, txdS, linkOkS})
  );

  upt_sync2 #(.W(1)) uSyncSig (
    .clk(clk),
    .rst(rst),
    .d(signalDetectPin),
    .q(signalDetS)
  );

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    upt_state_e state;
    upt_os_e osKind;
    logic [7:0] osData;
    logic osStrobe;
    upt_xmit_e xmit;
    logic anStart;
    logic initDone;
    logic forceIdle;
    logic gtxPrev;
    logic [EXT_DELAY-1:0] erPipe;
    logic [EXT_DELAY-1:0] extErrPipe;
  } upt_ctrl_s;

  upt_ctrl_s r;
  upt_ctrl_s next_r;

  // Ordered set sent while a state is being entered
  function automatic upt_os_e osFor(input upt_state_e st,
                                    input logic err,
                                    input logic extErr);
    upt_os_e k;
    k = OS_IDLE;
    case (st)
      ST_CONFIG: k = OS_CONFIG;
      ST_IDLE: k = OS_IDLE;
      ST_SOP: k = OS_SOP;
      ST_DATA: k = err ? OS_ERR_V : OS_DATA;
      ST_EOP_T: k = OS_EOP_T;
      ST_EOP_R: k = OS_EOP_R;
      ST_EXT: k = extErr ? OS_ERR_V : OS_EXT_R;
      default: k = OS_IDLE;
    endcase
    return k;
  endfunction

  // ****************************************************************
  // Next state
  // ****************************************************************
  logic tick;
  logic erLate;
  logic extErrLate;
  logic extErrNow;
  upt_xmit_e xmitNow;
  upt_state_e nst;

  always_comb begin
    next_r = r;
    tick = gtxClkS && !r.gtxPrev;
    erLate = r.erPipe[EXT_DELAY-1];
    extErrLate = r.extErrPipe[EXT_DELAY-1];
    extErrNow = (txdS == TXD_EXT_ERR);
    xmitNow = oneWayTxEnable ? XMIT_DATA : anXmit;
    nst = r.state;
    next_r.gtxPrev = gtxClkS;
    next_r.xmit = xmitNow;
    next_r.forceIdle = !linkOkS && !oneWayTxEnable;
    next_r.anStart = 1'b0;
    next_r.osStrobe = 1'b0;
    next_r.initDone = 1'b1;
    if (!oneWayTxEnable &&
        (!r.initDone ||
         (xmitNow == XMIT_CONFIG && r.state != ST_CONFIG))) begin
      next_r.anStart = 1'b1;
    end
    if (tick) begin
      next_r.erPipe = {r.erPipe[EXT_DELAY-2:0], txErS};
      next_r.extErrPipe = {r.extErrPipe[EXT_DELAY-2:0],
                           txErS && extErrNow};
      if (xmitNow == XMIT_CONFIG) begin
        nst = ST_CONFIG;
      end else begin
        case (r.state)
          ST_CONFIG: nst = ST_IDLE;
          ST_IDLE: begin
            if (txEnS && xmitNow == XMIT_DATA) begin
              nst = ST_SOP;
            end else begin
              nst = ST_IDLE;
            end
          end
          ST_SOP: nst = txEnS ? ST_DATA : ST_EOP_T;
          ST_DATA: nst = txEnS ? ST_DATA : ST_EOP_T;
          ST_EOP_T: nst = ST_EOP_R;
          ST_EOP_R: nst = erLate ? ST_EXT : ST_IDLE;
          ST_EXT: nst = erLate ? ST_EXT : ST_IDLE;
          default: nst = ST_IDLE;
        endcase
      end
      next_r.state = nst;
      next_r.osStrobe = 1'b1;
      next_r.osKind = osFor(nst, txErS,
                            nst == ST_EXT && erLate ? extErrLate
                                                    : 1'b0);
      next_r.osData = (nst == ST_DATA) ? txdS : DATA_ZERO;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      r <= '{state: ST_IDLE, osKind: OS_IDLE, osData: DATA_ZERO,
             osStrobe: 1'b0, xmit: XMIT_IDLE, anStart: 1'b0,
             initDone: 1'b0, forceIdle: 1'b0, gtxPrev: 1'b0,
             erPipe: '0, extErrPipe: '0};
    end else begin
      r <= next_r;
    end
  end

  // ****************************************************************
  // Fast-mode far-end fault path
  // ****************************************************************
  upt_fef_gen uFef (
    .clk(clk),
    .rst(rst),
    .signalOn(signalDetS),
    .oneWay(oneWayTxEnable),
    .forceIdle(r.forceIdle),
    .codeIn(fxCodeIn),
    .codeOut(fxCodeOut),
    .fefActive(fefActive)
  );

  assign osKind = r.osKind;
  assign osData = r.osData;
  assign osStrobe = r.osStrobe;
  assign xmitEff = r.xmit;
  assign anStart = r.anStart;
  assign fxForceIdle = r.forceIdle;
endmodule

// ===== rtl/upt_pkg.sv
package upt_pkg;

  // ****************************************************************
  // Ordered-set kinds handed to the code-group process
  // ****************************************************************
  typedef enum logic [3:0] {
    OS_IDLE, OS_CONFIG, OS_SOP, OS_DATA, OS_EOP_T, OS_EOP_R, OS_EXT_R,
    OS_ERR_V
  } upt_os_e;

  // Transmit select flag from auto-negotiation
  typedef enum logic [1:0] {
    XMIT_CONFIG, XMIT_IDLE, XMIT_DATA
  } upt_xmit_e;

  // Ordered-set process states
  typedef enum logic [2:0] {
    ST_CONFIG, ST_IDLE, ST_SOP, ST_DATA, ST_EOP_T, ST_EOP_R, ST_EXT
  } upt_state_e;

  // ****************************************************************
  // Constants
  // ****************************************************************
  localparam logic [7:0] TXD_EXT_ERR = 8'h1F;
  localparam logic [7:0] DATA_ZERO = 8'h00;
  localparam int EXT_DELAY = 2;
  localparam logic [4:0] FX_IDLE_CODE = 5'h1F;
  localparam logic [4:0] FEF_ONES_CODE = 5'h1F;
  localparam logic [4:0] FEF_LAST_CODE = 5'h1E;
  localparam int FEF_GROUPS = 17;
  localparam logic [4:0] FEF_LAST_IDX = 5'(FEF_GROUPS - 1);
  localparam logic [4:0] FEF_IDX_ZERO = 5'h00;
  localparam logic [4:0] FEF_IDX_ONE = 5'h01;

endpackage

// ===== rtl/upt_sync2.sv
`timescale 1ns/100ps
module upt_sync2 #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  import upt_pkg::*;

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } upt_sync_s;

  upt_sync_s r;
  upt_sync_s next_r;

  always_comb begin
    next_r = r;
    next_r.s1 = d;
    next_r.s2 = r.s1;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign q = r.s2;
endmodule

// ===== rtl/upt_fef_gen.sv
`timescale 1ns/100ps
module upt_fef_gen (
  input wire logic clk,
  input wire logic rst,
  input wire logic signalOn,
  input wire logic oneWay,
  input wire logic forceIdle,
  input wire logic [4:0] codeIn,
  output logic [4:0] codeOut,
  output logic fefActive
);
  import upt_pkg::*;

  typedef struct packed {
    logic [4:0] code;
    logic [4:0] idx;
    logic active;
  } upt_fef_s;

  upt_fef_s r;
  upt_fef_s next_r;

  always_comb begin
    next_r = r;
    if (signalOn || oneWay) begin
      next_r.active = 1'b0;
      next_r.idx = FEF_IDX_ZERO;
      next_r.code = forceIdle ? FX_IDLE_CODE : codeIn;
    end else begin
      next_r.active = 1'b1;
      next_r.code = (r.idx == FEF_LAST_IDX) ? FEF_LAST_CODE : FEF_ONES_CODE;
      next_r.idx = (r.idx == FEF_LAST_IDX) ? FEF_IDX_ZERO
                                             : r.idx + FEF_IDX_ONE;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      r <= '{code: FX_IDLE_CODE, idx: FEF_IDX_ZERO, active: 1'b0};
    end else begin
      r <= next_r;
    end
  end

  assign codeOut = r.code;
  assign fefActive = r.active;
endmodule

// ===== testbench/upt_tx_props.sv
`timescale 1ns/100ps
// ****************************************************************
// Transmit control checks
// ****************************************************************
module upt_tx_props (
  input wire logic clk,
  input wire logic rst,
  input wire logic oneWayTxEnable,
  input wire upt_pkg::upt_xmit_e anXmit,
  input wire logic linkOkPin,
  input wire logic signalDetectPin,
  input wire logic [4:0] fxCodeIn,
  input wire logic osStrobe,
  input wire upt_pkg::upt_xmit_e xmitEff,
  input wire logic anStart,
  input wire logic fxForceIdle,
  input wire logic [4:0] fxCodeOut,
  input wire logic fefActive
);
  import upt_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence linkDown;
    (!linkOkPin && !oneWayTxEnable) [*5];
  endsequence
  sequence sigOff;
    (!signalDetectPin && !oneWayTxEnable) [*5];
  endsequence
  sequence toConfig;
    (!oneWayTxEnable && anXmit != XMIT_CONFIG)
    ##1 (!oneWayTxEnable && anXmit == XMIT_CONFIG);
  endsequence
  a_xmit_oneway: assert property (oneWayTxEnable |=>
    xmitEff == XMIT_DATA) else $error("select not DATA");
  a_xmit_follow: assert property (!oneWayTxEnable |=>
    xmitEff == $past(anXmit)) else $error("select not followed");
  a_an_oneway: assert property (anStart |->
    !$past(oneWayTxEnable)) else $error("negotiation in one-way");
  a_an_config: assert property (toConfig |=> anStart)
    else $error("negotiation not started");
  a_strobe_gap: assert property (osStrobe |=>
    (!osStrobe [*6]) ##[1:4] osStrobe) else $error("set gap");
  a_idle_force: assert property (linkDown |-> fxForceIdle)
    else $error("link down not idle");
  a_oneway_pass: assert property (oneWayTxEnable |=>
    !fxForceIdle && !fefActive) else $error("one-way gated");
  a_code_pass: assert property (!$past(rst) && !$past(fxForceIdle) &&
    !fefActive |-> fxCodeOut == $past(fxCodeIn)) else $error("code lost");
  a_idle_code: assert property ($past(fxForceIdle) && !fefActive |->
    fxCodeOut == FX_IDLE_CODE) else $error("idle not forced");
  a_fef_on: assert property (sigOff |-> fefActive)
    else $error("no fault pattern");
endmodule
bind upt_tx_ctrl upt_tx_props props (.*);

// ===== testbench/upt_mac_model.sv
`timescale 1ns/100ps
// ****************************************************************
// Reconciliation side driving the gigabit pins
// ****************************************************************
module upt_mac_model (
  output logic gtxClk,
  output logic txEn,
  output logic txEr,
  output logic [7:0] txd
);
  import upt_pkg::*;
  logic [7:0] db[64];
  initial begin
    gtxClk = 1'b0;
    txEn = 1'b0;
    txEr = 1'b0;
    txd = 8'h00;
  end
  always #200 gtxClk = ~gtxClk;
  // Pins change mid-period, away from the rising edge
  task send(input int n, input int e, input int x, input int v);
    for (int i = 0; i < n + x + 1; i++) begin
      @(negedge gtxClk);
      txEn = i < n;
      txEr = i == e || (i >= n && i < n + x);
      if (i >= n && i < n + x)
        txd = (i == n + v) ? TXD_EXT_ERR : 8'h0F;
      else
        txd = 8'($urandom);
      db[i] = txd;
    end
  endtask
endmodule

// ===== testbench/testbench.sv
`timescale 1ns/100ps
// ****************************************************************
// Bench for the transmit control block
// ****************************************************************
module testbench;
  import upt_pkg::*;
  logic clk = 0, rst = 1, oneWay = 0, linkOk = 1, sigDet = 1;
  logic gtx, txEn, txEr, osStrobe, anStart, fxIdle, fef, seen;
  logic [7:0] txd, osData, got, dq[$];
  logic [4:0] fxIn = 5'h00, fxOut;
  upt_xmit_e anXmit = XMIT_DATA, xmitEff;
  upt_os_e osKind, q[$];
  int err_count = 0, checks = 0, k;
  int es[6] = '{-1, 0, 1, -1, -1, 1}, xs[6] = '{0, 0, 0, 1, 3, 2};
  int vs[6] = '{-1, -1, -1, -1, 1, 0};
  always #25 clk = ~clk;
  always @(negedge clk) fxIn <= 5'($urandom);
  always @(posedge clk) begin
    if (osStrobe === 1'b1) begin
      q.push_back(osKind);
      dq.push_back(osData);
    end
  end
  upt_mac_model mac (.gtxClk(gtx), .txEn(txEn), .txEr(txEr), .txd(txd));
  upt_tx_ctrl uut (.clk(clk), .rst(rst), .oneWayTxEnable(oneWay),
    .anXmit(anXmit), .gtxClkPin(gtx), .txEnPin(txEn), .txErPin(txEr),
    .txdPin(txd), .linkOkPin(linkOk), .signalDetectPin(sigDet),
    .fxCodeIn(fxIn), .osKind(osKind), .osData(osData),
    .osStrobe(osStrobe), .xmitEff(xmitEff), .anStart(anStart),
    .fxForceIdle(fxIdle), .fxCodeOut(fxOut), .fefActive(fef));
  task chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task close_out;
    $display("checks=%0d mismatches=%0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  function automatic logic [7:0] expk(int i, int n, int e, int x, int v);
    if (i == 0) return 8'(OS_SOP);
    if (i < n) return 8'(i == e ? OS_ERR_V : OS_DATA);
    if (i == n) return 8'(OS_EOP_T);
    if (i == n + 1) return 8'(OS_EOP_R);
    if (i < n + 2 + x) return 8'(i - n - 2 == v ? OS_ERR_V : OS_EXT_R);
    return 8'(OS_IDLE);
  endfunction
  task frame(input int n, input int e, input int x, input int v);
    repeat (2) @(negedge clk);
    q.delete();
    dq.delete();
    mac.send(n, e, x, v);
    repeat (48) @(negedge clk);
    k = 0;
    while (k < q.size() && q[k] == OS_IDLE) k++;
    if (anXmit != XMIT_DATA && oneWay == 1'b0)
      chk(8'(k == q.size()), 8'h01);
    else for (int i = 0; i < n + 3 + x; i++) begin
      got = k + i < q.size() ? 8'(q[k + i]) : 8'hFF;
      chk(got, expk(i, n, e, x, v));
      if (i > 0 && i < n && k + i < dq.size())
        chk(dq[k + i], mac.db[i]);
    end
    $display("frame of %0d done", n);
  endtask
  initial begin
    void'($urandom(11501));
    repeat (3) @(negedge clk);
    rst = 0;
    @(negedge clk);
    chk(8'(anStart), 8'h01);
    for (int t = 0; t < 6; t++) begin
      k = 2 + $urandom % 5;
      frame(k, es[t], xs[t], vs[t]);
    end
    oneWay = 1;
    anXmit = XMIT_CONFIG;
    linkOk = 0;
    sigDet = 0;
    repeat (4) @(negedge clk);
    chk(8'(xmitEff), 8'(XMIT_DATA));
    chk(8'(fxIdle), 8'h00);
    chk(8'(fef), 8'h00);
    frame(4, -1, 0, -1);
    oneWay = 0;
    sigDet = 1;
    repeat (6) @(negedge clk);
    chk(8'(fxIdle), 8'h01);
    chk(8'(fxOut), 8'(FX_IDLE_CODE));
    chk(8'(fef), 8'h00);
    linkOk = 1;
    sigDet = 0;
    anXmit = XMIT_IDLE;
    frame(3, -1, 0, -1);
    chk(8'(fef), 8'h01);
    k = 0;
    while (k < 40 && fxOut !== FEF_LAST_CODE) begin
      @(negedge clk);
      k++;
    end
    chk(8'(fxOut), 8'(FEF_LAST_CODE));
    repeat (FEF_GROUPS) @(negedge clk);
    chk(8'(fxOut), 8'(FEF_LAST_CODE));
    sigDet = 1;
    anXmit = XMIT_CONFIG;
    seen = 0;
    repeat (4) @(negedge clk) seen = seen | anStart;
    chk(8'(seen), 8'h01);
    chk(8'(fef), 8'h00);
    $display("fast path and negotiation done");
    close_out();
  end
  initial begin
    #4000000;
    err_count++;
    close_out();
  end
endmodule
